// file: src/wake_timer_regs.svh
// Register offsets, field positions, reset values and timing counts of the wake timer.
// Assumes an 8-bit register port; included by bare name.
`ifndef WAKE_TIMER_REGS_SVH
`define WAKE_TIMER_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WT_ADDR_INT_STATUS1     8'h03
`define WT_ADDR_INT_STATUS2     8'h04
`define WT_ADDR_INT_ENABLE2     8'h06
`define WT_ADDR_CONTROL         8'h07
`define WT_ADDR_PERIOD_EXP      8'h14
`define WT_ADDR_PERIOD_MANT_HI  8'h15
`define WT_ADDR_PERIOD_MANT_LO  8'h16
`define WT_ADDR_COUNT_HI        8'h17
`define WT_ADDR_COUNT_LO        8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WT_BIT_EXPIRY           3
`define WT_BIT_CTRL_READY       0
`define WT_BIT_CTRL_XTAL_SEL    4
`define WT_BIT_CTRL_TIMER_EN    5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WT_RST_PERIOD_EXP       5'h03
`define WT_RST_MANT_HI          8'h00
`define WT_RST_MANT_LO          8'h00
`define WT_RST_CONTROL          8'h00
`define WT_RST_INT_ENABLE2      8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WT_SYS_CLK_HZ           250000000
`define WT_LF_CLK_HZ            32768
`define WT_RC_DIV               (`WT_SYS_CLK_HZ / `WT_LF_CLK_HZ)
`define WT_PERIOD_UNIT_TICKS    36'd32

`endif

// file: src/wake_timer_pkg.sv
// Types shared by the wake timer design files.
// Assumes nothing of its surroundings.
package wake_timer_pkg;

    // ------------------------------------------------------------------------
    // Power state seen by the rest of the transceiver
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b001,
        ST_READY = 3'b010,
        ST_WOKEN = 3'b100
    } wt_state_t;

endpackage : wake_timer_pkg

// file: src/lf_tick_if.sv
// Low-frequency time base carrier between the tick generator and its users.
// Assumes all ends run on the system clock.
`timescale 1ns/1ps
interface lf_tick_if;
    logic tick;      // One-cycle pulse per 32.768 kHz period
    logic use_xtal;  // Time base taken from the external crystal

    modport src  (input use_xtal, output tick);
    modport ctl  (output use_xtal);
    modport sink (input tick);
endinterface : lf_tick_if

// file: src/lf_tick_gen.sv
// Low-frequency tick generator: internal RC divider or external crystal pin.
// Assumes crystal pin is asynchronous to the system clock.
`timescale 1ns/1ps
`include "wake_timer_regs.svh"
module lf_tick_gen #(
    parameter int unsigned RC_DIV = `WT_RC_DIV
) (
    input  wire logic  clk_in,       // System clock
    input  wire logic  rst_n_in,     // Synchronised reset, active low
    input  wire logic  xtal_pin_in,  // External 32 kHz crystal level
    lf_tick_if.src     lf            // Tick out, source select in
);

    logic [12:0] div_q;
    logic [12:0] div_d;
    logic [2:0]  xs_q;
    logic [2:0]  xs_d;
    logic        tick_q;
    logic        tick_d;

    // ------------------------------------------------------------------------
    // Divider and crystal edge detect
    // ------------------------------------------------------------------------
    always_comb begin
        xs_d   = {xs_q[1:0], xtal_pin_in};
        div_d  = (div_q == 13'(RC_DIV - 1)) ? 13'h0000 : div_q + 13'h0001;
        if (lf.use_xtal) begin
            tick_d = xs_q[1] & ~xs_q[2];
        end else begin
            tick_d = (div_q == 13'(RC_DIV - 1));
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_q  <= 13'h0000;
            xs_q   <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            xs_q   <= xs_d;
            tick_q <= tick_d;
        end
    end

    assign lf.tick = tick_q;

    a_rc_tick_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (tick_q && $past(!lf.use_xtal)) |-> (div_q == 13'h0000))
        else $error("RC tick not aligned to divider wrap");

endmodule : lf_tick_gen

// file: src/wake_period_counter.sv
// Wake period counter: prescaler of 32 * 2^exponent ticks, then mantissa count.
// Assumes one-cycle ticks from the low-frequency tick generator.
`timescale 1ns/1ps
module wake_period_counter (
    input  wire logic        clk_in,       // System clock
    input  wire logic        rst_n_in,     // Synchronised reset, active low
    lf_tick_if.sink          lf,           // Low-frequency ticks
    input  wire logic        run_in,       // Timer enabled
    input  wire logic [4:0]  exponent_in,  // Period exponent
    input  wire logic [15:0] mantissa_in,  // Period mantissa
    output logic             expire_out,   // One-cycle pulse at period end
    output logic [15:0]      count_out     // Live count
);
    `include "wake_timer_regs.svh"

    logic [35:0] presc_q;
    logic [35:0] presc_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        expire_q;
    logic        expire_d;

    function automatic logic [35:0] presc_last(input logic [4:0] exp_v);
        presc_last = (`WT_PERIOD_UNIT_TICKS << exp_v) - 36'd1;
    endfunction : presc_last

    // ------------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------------
    always_comb begin
        presc_d  = presc_q;
        count_d  = count_q;
        expire_d = 1'b0;
        if (!run_in) begin
            presc_d = 36'h0;
            count_d = 16'h0000;
        end else if (lf.tick) begin
            if (presc_q >= presc_last(exponent_in)) begin
                presc_d = 36'h0;
                if (count_q + 16'h0001 == mantissa_in) begin
                    count_d  = 16'h0000;
                    expire_d = 1'b1;
                end else begin
                    count_d = count_q + 16'h0001;
                end
            end else begin
                presc_d = presc_q + 36'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_q  <= 36'h0;
            count_q  <= 16'h0000;
            expire_q <= 1'b0;
        end else begin
            presc_q  <= presc_d;
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign expire_out = expire_q;
    assign count_out  = count_q;

    a_restart_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        expire_q |-> (count_q == 16'h0000))
        else $error("Count did not restart at expiry");

    a_presc_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (run_in && lf.tick && presc_q < presc_last(exponent_in))
            |=> presc_q == $past(presc_q) + 36'h1)
        else $error("Prescaler step wrong");

endmodule : wake_period_counter

// file: src/radio_wakeup_timer.sv
// Wake timer of the radio transceiver: register port, power state, interrupt.
// Assumes a host on the same clock using one-cycle read and write strobes.
`timescale 1ns/1ps
`include "wake_timer_regs.svh"

// Overview of operation
// - Default time base is the internal RC source at 32.768 kHz.
// - With timer enable set, counting continues through SLEEP.
// - Expiry with interrupt enabled drives the interrupt pin low.
// - Live 16-bit count readable anytime, high byte then low byte.
// - Period is 32 * mantissa * 2^exponent low-frequency ticks.
// - Exponent is bits 4..0, resets to 03h; mantissa bytes reset 00h.
// - Enabled expiry wakes the device so its crystal and clock output run.
// - With interrupt disabled, expiry only shows on GPIO; state unchanged.
// - Crystal select reconfigures the first GPIO pin for the crystal.
// - Crystal select times timer, clock output and low duty receive.
// - Timer interrupt enable bit chooses pin interrupt or GPIO only.
// - Pending interrupt keeps the clock running until the host reads it.
// - The period exponent also sets the low duty receive duration exponent.
module radio_wakeup_timer #(
    parameter int unsigned RC_DIV = `WT_RC_DIV
) (
    input  wire logic       sys_clk_in,              // 250 MHz system clock
    input  wire logic       rst_n_in,                // Async reset, active low
    input  wire logic [7:0] addr_in,                 // Register address
    input  wire logic [7:0] wr_data_in,              // Write data
    input  wire logic       wr_en_in,                // Write strobe
    input  wire logic       rd_en_in,                // Read strobe
    input  wire logic       xtal_pin_in,             // External crystal level
    output logic [7:0]      rd_data_out,             // Read data, cycle after strobe
    output logic            interrupt_request_pin_n_out, // Interrupt, active low
    output logic            xtal_run_out,            // 30 MHz crystal and clock out on
    output logic            wake_gpio_out,           // GPIO timer indication
    output logic            gpio0_xtal_mode_out,     // First GPIO given to crystal
    output logic            lf_from_xtal_out,        // Clock out and receive timed by crystal
    output logic [4:0]      low_duty_rx_exponent_out // Receive duration exponent
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Time base and period counter
    // ------------------------------------------------------------------------
    lf_tick_if   lf_bus ();
    logic        expire;
    logic [15:0] count;
    logic [4:0]  exp_q;
    logic [7:0]  mant_hi_q;
    logic [7:0]  mant_lo_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  int_en_q;

    assign lf_bus.use_xtal = ctrl_q[`WT_BIT_CTRL_XTAL_SEL];

    lf_tick_gen #(
        .RC_DIV (RC_DIV)
    ) u_tick (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_n),
        .xtal_pin_in (xtal_pin_in),
        .lf          (lf_bus.src)
    );

    wake_period_counter u_period (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_n),
        .lf          (lf_bus.sink),
        .run_in      (ctrl_q[`WT_BIT_CTRL_TIMER_EN]),
        .exponent_in (exp_q),
        .mantissa_in ({mant_hi_q, mant_lo_q}),
        .expire_out  (expire),
        .count_out   (count)
    );

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    logic [4:0] exp_d;
    logic [7:0] mant_hi_d;
    logic [7:0] mant_lo_d;
    logic [7:0] ctrl_d;
    logic [7:0] int_en_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       status_rd;
    logic       pending;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
        hit = (a == offs);
    endfunction : hit

    assign status_rd = rd_en_in && hit(addr_in, `WT_ADDR_INT_STATUS2);
    assign pending   = status_q[`WT_BIT_EXPIRY] & int_en_q[`WT_BIT_EXPIRY];

    always_comb begin
        exp_d     = exp_q;
        mant_hi_d = mant_hi_q;
        mant_lo_d = mant_lo_q;
        ctrl_d    = ctrl_q;
        int_en_d  = int_en_q;
        if (wr_en_in) begin
            if (hit(addr_in, `WT_ADDR_PERIOD_EXP)) begin
                exp_d = wr_data_in[4:0];
            end
            if (hit(addr_in, `WT_ADDR_PERIOD_MANT_HI)) begin
                mant_hi_d = wr_data_in;
            end
            if (hit(addr_in, `WT_ADDR_PERIOD_MANT_LO)) begin
                mant_lo_d = wr_data_in;
            end
            if (hit(addr_in, `WT_ADDR_CONTROL)) begin
                ctrl_d = wr_data_in;
            end
            if (hit(addr_in, `WT_ADDR_INT_ENABLE2)) begin
                int_en_d = wr_data_in & (8'h01 << `WT_BIT_EXPIRY);
            end
        end
        // Status: read clears, a same-cycle expiry wins
        status_d = status_rd ? 8'h00 : status_q;
        if (expire) begin
            status_d[`WT_BIT_EXPIRY] = 1'b1;
        end
        rd_data_d = 8'h00;
        if (rd_en_in) begin
            case (addr_in)
                `WT_ADDR_INT_STATUS1:    rd_data_d = 8'h00;
                `WT_ADDR_INT_STATUS2:    rd_data_d = status_q;
                `WT_ADDR_INT_ENABLE2:    rd_data_d = int_en_q;
                `WT_ADDR_CONTROL:        rd_data_d = ctrl_q;
                `WT_ADDR_PERIOD_EXP:     rd_data_d = {3'h0, exp_q};
                `WT_ADDR_PERIOD_MANT_HI: rd_data_d = mant_hi_q;
                `WT_ADDR_PERIOD_MANT_LO: rd_data_d = mant_lo_q;
                `WT_ADDR_COUNT_HI:       rd_data_d = count[15:8];
                `WT_ADDR_COUNT_LO:       rd_data_d = count[7:0];
                default:                 rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            exp_q     <= `WT_RST_PERIOD_EXP;
            mant_hi_q <= `WT_RST_MANT_HI;
            mant_lo_q <= `WT_RST_MANT_LO;
            ctrl_q    <= `WT_RST_CONTROL;
            int_en_q  <= `WT_RST_INT_ENABLE2;
            status_q  <= 8'h00;
            rd_data_q <= 8'h00;
        end else begin
            exp_q     <= exp_d;
            mant_hi_q <= mant_hi_d;
            mant_lo_q <= mant_lo_d;
            ctrl_q    <= ctrl_d;
            int_en_q  <= int_en_d;
            status_q  <= status_d;
            rd_data_q <= rd_data_d;
        end
    end

    // ------------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------------
    wake_timer_pkg::wt_state_t state_q;
    wake_timer_pkg::wt_state_t state_d;

    always_comb begin
        case (state_q)
            wake_timer_pkg::ST_SLEEP,
            wake_timer_pkg::ST_READY,
            wake_timer_pkg::ST_WOKEN: begin
                if (pending) begin
                    state_d = wake_timer_pkg::ST_WOKEN;
                end else if (ctrl_q[`WT_BIT_CTRL_READY]) begin
                    state_d = wake_timer_pkg::ST_READY;
                end else begin
                    state_d = wake_timer_pkg::ST_SLEEP;
                end
            end
            default: state_d = wake_timer_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= wake_timer_pkg::ST_SLEEP;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------------
    logic       irq_n_q;
    logic       xtal_run_q;
    logic       wake_gpio_q;
    logic       gpio0_xtal_q;
    logic       lf_xtal_q;
    logic [4:0] ldc_exp_q;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_q      <= 1'b1;
            xtal_run_q   <= 1'b0;
            wake_gpio_q  <= 1'b0;
            gpio0_xtal_q <= 1'b0;
            lf_xtal_q    <= 1'b0;
            ldc_exp_q    <= `WT_RST_PERIOD_EXP;
        end else begin
            irq_n_q      <= ~pending;
            xtal_run_q   <= (state_q != wake_timer_pkg::ST_SLEEP);
            wake_gpio_q  <= status_q[`WT_BIT_EXPIRY];
            gpio0_xtal_q <= ctrl_q[`WT_BIT_CTRL_XTAL_SEL];
            lf_xtal_q    <= ctrl_q[`WT_BIT_CTRL_XTAL_SEL];
            ldc_exp_q    <= exp_q;
        end
    end

    assign rd_data_out                 = rd_data_q;
    assign interrupt_request_pin_n_out = irq_n_q;
    assign xtal_run_out                = xtal_run_q;
    assign wake_gpio_out               = wake_gpio_q;
    assign gpio0_xtal_mode_out         = gpio0_xtal_q;
    assign lf_from_xtal_out            = lf_xtal_q;
    assign low_duty_rx_exponent_out    = ldc_exp_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_irq_on_expiry: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (expire && int_en_q[`WT_BIT_EXPIRY] && !wr_en_in) |=> ##1 !irq_n_q)
        else $error("Interrupt pin not low after enabled expiry");

    a_irq_gpio_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !int_en_q[`WT_BIT_EXPIRY] |=> irq_n_q)
        else $error("Interrupt pin low while interrupt disabled");

    a_status_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (status_q[`WT_BIT_EXPIRY] && !status_rd) |=> status_q[`WT_BIT_EXPIRY])
        else $error("Expiry status lost without a read");

    a_set_beats_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        expire |=> status_q[`WT_BIT_EXPIRY])
        else $error("Expiry lost against a status read");

    a_wake_xtal_run: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (expire && int_en_q[`WT_BIT_EXPIRY] && !wr_en_in) |=> ##2 xtal_run_q)
        else $error("Crystal not running after wake");

    a_sleep_stays: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!pending && !ctrl_q[`WT_BIT_CTRL_READY]) |=> state_q == wake_timer_pkg::ST_SLEEP)
        else $error("State changed without command or interrupt");

    a_pending_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        pending |=> (state_q == wake_timer_pkg::ST_WOKEN) ##1 xtal_run_q)
        else $error("Clock stopped while interrupt pending");

    a_count_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (rd_en_in && hit(addr_in, `WT_ADDR_COUNT_HI)) |=> rd_data_q == $past(count[15:8]))
        else $error("Count high byte misread");

    a_ldc_exponent: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $changed(exp_q) |=> low_duty_rx_exponent_out == $past(exp_q))
        else $error("Receive duration exponent not following period exponent");

    a_gpio0_xtal: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        ctrl_q[`WT_BIT_CTRL_XTAL_SEL] |=> gpio0_xtal_mode_out && lf_from_xtal_out)
        else $error("First GPIO not handed to crystal");

    a_rd_idle_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !rd_en_in |=> rd_data_q == 8'h00)
        else $error("Read data not zero outside read answer");

    a_gpio_follows: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        status_q[`WT_BIT_EXPIRY] |=> wake_gpio_out)
        else $error("GPIO timer indication missing while expiry pending");

    a_ready_command: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!pending && ctrl_q[`WT_BIT_CTRL_READY]) |=> state_q == wake_timer_pkg::ST_READY)
        else $error("Commanded mode not taken with no interrupt pending");

    a_irq_from_pending: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !irq_n_q |-> $past(pending))
        else $error("Interrupt pin low with no enabled expiry pending");

endmodule : radio_wakeup_timer

// file: tb/host_mcu_model.sv
// Host microcontroller model: register port master and wake interrupt service.
// Assumes one-cycle read latency and the timer's system clock.
`timescale 1ns/1ps
`include "wake_timer_regs.svh"
module host_mcu_model (
    input  wire logic       clk_in,      // System clock
    input  wire logic [7:0] rd_data_in,  // Read data from the timer
    output logic [7:0]      addr_out,    // Register address
    output logic [7:0]      wr_data_out, // Write data
    output logic            wr_en_out,   // Write strobe
    output logic            rd_en_out    // Read strobe
);
    initial begin
        addr_out = 8'h00;
        wr_data_out = 8'h00;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    end

    // Data lines are scrambled once a write is over so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        @(posedge clk_in);
        d = rd_data_in;
    endtask : rd

    // Confirms a wake event after a chosen delay, prompt or slow
    task automatic service(input int dly, output logic [7:0] st2);
        logic [7:0] st1;
        repeat (dly) @(posedge clk_in);
        rd(`WT_ADDR_INT_STATUS1, st1);
        rd(`WT_ADDR_INT_STATUS2, st2);
    endtask : service
endmodule : host_mcu_model

// file: tb/tb.sv
// Self-checking bench of the wake timer with a host model on the register port.
// Assumes a shortened RC divider so periods stay about a thousand cycles.
`timescale 1ns/1ps
`include "wake_timer_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb;
    localparam int unsigned RC = 8;
    localparam int          E  = 1024;
    logic       sys_clk_in, rst_n_in, xtal_pin_in, wr_en, rd_en;
    logic       irq_n, xtal_run, wake_gpio, gpio0_xtal, lf_xtal;
    logic [7:0] addr, wdata, rdata, st;
    logic [4:0] ld_exp;
    int         mismatches, num_checks, cyc, n, k;

    radio_wakeup_timer #(.RC_DIV(RC)) i_radio_wakeup_timer (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .xtal_pin_in(xtal_pin_in), .rd_data_out(rdata),
        .interrupt_request_pin_n_out(irq_n), .xtal_run_out(xtal_run),
        .wake_gpio_out(wake_gpio), .gpio0_xtal_mode_out(gpio0_xtal),
        .lf_from_xtal_out(lf_xtal), .low_duty_rx_exponent_out(ld_exp));
    host_mcu_model i_host_mcu_model (.clk_in(sys_clk_in), .rd_data_in(rdata),
        .addr_out(addr), .wr_data_out(wdata), .wr_en_out(wr_en), .rd_en_out(rd_en));

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------------------
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        i_host_mcu_model.rd(a, d);
        `CHK(nm, e, d)
    endtask : chk_rd
    task automatic wait_ev(input bit pin, output int m);
        m = 0;
        while ((pin ? irq_n : ~wake_gpio) !== 1'b0 && m < 5000) begin
            @(posedge sys_clk_in);
            m++;
        end
    endtask : wait_ev

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        `CHK("irq idle", 1'b1, irq_n)
        `CHK("rx exponent", 5'h03, ld_exp)
        chk_rd(`WT_ADDR_PERIOD_EXP, 8'h03, "exp reset");
        chk_rd(`WT_ADDR_PERIOD_MANT_HI, 8'h00, "mant hi reset");
        chk_rd(`WT_ADDR_PERIOD_MANT_LO, 8'h00, "mant lo reset");
        chk_rd(`WT_ADDR_CONTROL, 8'h00, "control reset");
        chk_rd(`WT_ADDR_INT_ENABLE2, 8'h00, "enable reset");
        chk_rd(8'h20, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_regs();
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_EXP, 8'hff);
        chk_rd(`WT_ADDR_PERIOD_EXP, 8'h1f, "exp width");
        `CHK("rx exponent", 5'h1f, ld_exp)
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_MANT_HI, 8'ha5);
        chk_rd(`WT_ADDR_PERIOD_MANT_HI, 8'ha5, "mant hi");
        i_host_mcu_model.wr(`WT_ADDR_COUNT_HI, 8'hff);
        chk_rd(`WT_ADDR_COUNT_HI, 8'h00, "count read only");
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge sys_clk_in);
        `CHK("ready command", 1'b1, xtal_run)
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h00);
    endtask : t_regs
    task automatic t_wake_irq();
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_EXP, 8'h01);
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_MANT_HI, 8'h00);
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_MANT_LO, 8'h02);
        i_host_mcu_model.wr(`WT_ADDR_INT_ENABLE2, 8'h08);
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h20);
        repeat (600) @(posedge sys_clk_in);
        chk_rd(`WT_ADDR_COUNT_HI, 8'h00, "count hi");
        chk_rd(`WT_ADDR_COUNT_LO, 8'h01, "count lo");
        wait_ev(1'b1, n);
        n = n + 608;
        `CHK("irq period", 1'b1, n >= E - 2 * RC && n <= E + 2 * RC + 12)
        repeat (20) @(posedge sys_clk_in);
        `CHK("crystal on", 1'b1, xtal_run)
        `CHK("irq pending", 1'b0, irq_n)
        i_host_mcu_model.service(0, st);
        `CHK("status", 8'h08, st)
        repeat (3) @(posedge sys_clk_in);
        `CHK("irq cleared", 1'b1, irq_n)
        `CHK("crystal off", 1'b0, xtal_run)
        wait_ev(1'b1, n);
        n = n + 31;
        `CHK("repeat period", 1'b1, n >= E - 2 * RC && n <= E + 2 * RC + 12)
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h00);
        i_host_mcu_model.service(4, st);
    endtask : t_wake_irq
    task automatic t_wake_gpio();
        i_host_mcu_model.wr(`WT_ADDR_INT_ENABLE2, 8'h00);
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h20);
        wait_ev(1'b0, n);
        repeat (3) @(posedge sys_clk_in);
        `CHK("gpio expiry", 1'b1, wake_gpio)
        `CHK("no pin irq", 1'b1, irq_n)
        `CHK("state kept", 1'b0, xtal_run)
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h00);
        i_host_mcu_model.service(0, st);
        `CHK("gpio status", 8'h08, st)
    endtask : t_wake_gpio
    task automatic t_xtal();
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_EXP, 8'h00);
        i_host_mcu_model.wr(`WT_ADDR_PERIOD_MANT_LO, 8'h01);
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h30);
        repeat (3) @(posedge sys_clk_in);
        `CHK("gpio0 crystal", 1'b1, gpio0_xtal)
        `CHK("lf crystal", 1'b1, lf_xtal)
        for (k = 0; k < 40 && wake_gpio !== 1'b1; k++) begin
            repeat (16) @(posedge sys_clk_in);
            xtal_pin_in <= 1'b1;
            repeat (16) @(posedge sys_clk_in);
            xtal_pin_in <= 1'b0;
        end
        `CHK("crystal ticks", 1'b1, k >= 31 && k <= 33)
        i_host_mcu_model.wr(`WT_ADDR_CONTROL, 8'h00);
        i_host_mcu_model.service(0, st);
    endtask : t_xtal

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        rst_n_in = 1'b0;
        xtal_pin_in = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        t_reset();
        t_regs();
        t_wake_irq();
        t_wake_gpio();
        t_xtal();
        results();
    end
endmodule : tb
